// ### rtl/wake_cfg_pkg.sv
// Purpose: constants and carrier types for the bus and wake source configuration bank
// Assumes: 7-bit register index on a decoded register port from the serial front end
// Notes: register fields below are bit positions inside 8-bit registers
// Behaviour
// - transceiver mode field: 00 off, 01 wake capable, 10 receive only, 11 normal
// - reserved bits always read back as zero
// - fail-safe entry by failure forces bus control register to 0000 0001
// - in development mode the reset transceiver mode is normal
// - internal wake bit 6 enables timer as cyclic wake source
// - internal wake bit 2 stops watchdog in stop mode, cleared on stop to normal
// - global interrupt bit: clear means only wakes drive interrupt, set means all status
// - wake-or-measure bit set turns wake pin into voltage sense, no wake events
// - measure selected and fail output idle: measure in normal mode, ignore wake enable, gpio
// - with fail output active, setting measure select from zero to one is refused and flags spi failure
// - while measuring, wake pin and gpio level flags hold reset and stop updating
// - external wake bit 0 enables wake pin as source, powers up enabled
// - fail-safe entry without measuring forces external wake register to x0x0 0001
// - fail-safe entry while measuring does not auto-enable the wake pin
// - gpio pull field applies only for gpio wake use: none, down, up, auto
// - wake pin pull field: none, down, up, automatic switching
// - restart keeps both pull fields and clears the remaining bits
// - restart clears bus control upper six bits, mode depends on cause
// - restart keeps global interrupt, measure select and wake pin enable only
// - restart keeps timer wake enable only, clearing watchdog stop disable
package wake_cfg_pkg;
	localparam logic [6:0] ADDR_BUS_MODE = 7'h04;
	localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
	localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
	localparam logic [6:0] ADDR_PULL_CFG = 7'h08;
	// writable masks; reserved positions are zero here
	localparam logic [7:0] MASK_BUS_MODE = 8'h03;
	localparam logic [7:0] MASK_INT_WAKE = 8'h44;
	localparam logic [7:0] MASK_EXT_WAKE = 8'hA1;
	localparam logic [7:0] MASK_PULL_CFG = 8'hC3;
	// restart keep masks
	localparam logic [7:0] KEEP_INT_WAKE = 8'h40;
	localparam logic [7:0] KEEP_EXT_WAKE = 8'hA1;
	localparam logic [7:0] KEEP_PULL_CFG = 8'hC3;
	// reset and forced values
	localparam logic [7:0] RST_BUS_MODE = 8'h00;
	localparam logic [7:0] RST_INT_WAKE = 8'h00;
	localparam logic [7:0] RST_EXT_WAKE = 8'h01;
	localparam logic [7:0] RST_PULL_CFG = 8'h00;
	localparam logic [7:0] FS_BUS_MODE = 8'h01;
	localparam logic [7:0] FS_EXT_KEEP = 8'hA0;
	localparam logic [7:0] FS_EXT_SET = 8'h01;
	// field positions
	localparam int BIT_TIMER_WAKE = 6;
	localparam int BIT_DOG_STOP = 2;
	localparam int BIT_GLOBAL_IRQ = 7;
	localparam int BIT_MEASURE = 5;
	localparam int BIT_WAKE_EN = 0;
	localparam int PULL_GPIO_HI = 7;
	localparam int PULL_GPIO_LO = 6;
	localparam int PULL_WAKE_HI = 1;
	localparam int PULL_WAKE_LO = 0;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_WAKE = 2'h1;
	localparam logic [1:0] MODE_RX_ONLY = 2'h2;
	localparam logic [1:0] MODE_NORMAL = 2'h3;
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;
	localparam logic [1:0] PULL_AUTO = 2'h3;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic off;
		logic wake_only;
		logic rx_only;
		logic normal;
	} xcvr_mode_s;

	typedef struct packed {
		logic none;
		logic down;
		logic up;
		logic auto_sw;
	} pull_sel_s;

	// one-hot view of a two-bit pull field
	function automatic pull_sel_s decode_pull(input logic [1:0] f);
		pull_sel_s p;
		p.none = (f == PULL_NONE);
		p.down = (f == PULL_DOWN);
		p.up = (f == PULL_UP);
		p.auto_sw = (f == PULL_AUTO);
		return p;
	endfunction
endpackage

// ### rtl/level_flag_hold.sv
// Purpose: synchronise a pin level into a status flag that can be frozen at reset value
// Assumes: pin is asynchronous to clk
// Notes: first stage feeds only the second stage
module level_flag_hold
	import wake_cfg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// pin and control
	input wire logic pin,
	input wire logic hold,
	// status
	output logic flag
);
	logic s1_q, s1_d, s2_q, s2_d, flag_q, flag_d;

	// two-stage synchroniser, then the held flag
	always_comb begin
		s1_d = pin;
		s2_d = s1_q;
		flag_d = hold ? 1'b0 : s2_q;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			flag_q <= flag_d;
		end
	end

	assign flag = flag_q;
endmodule

// ### rtl/bus_and_wake_source_config.sv
// Purpose: bus transceiver mode and wake source configuration registers
// Assumes: serial front end hands over decoded one-cycle read and write strobes
// Notes: mode state machine lives outside; it pulses entry events into this block
module bus_and_wake_source_config
	import wake_cfg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port from the serial front end
	input wire reg_req_s req,
	output logic [7:0] rdata,
	output logic hit,
	output logic spi_fail_set,
	// device mode events and levels
	input wire logic dev_mode,
	input wire logic failsafe_entry,
	input wire logic restart_entry,
	input wire logic [1:0] restart_mode,
	input wire logic stop_to_normal,
	input wire logic in_normal,
	input wire logic fail_output,
	// pins
	input wire logic hv_wake_pin,
	input wire logic gpio_pin,
	input wire logic gpio_is_wake,
	// event sources for the interrupt line
	input wire logic wake_event,
	input wire logic status_event,
	// decoded configuration
	output xcvr_mode_s xcvr_mode,
	output logic timer_wake_enable,
	output logic dog_stop_disable_hi,
	output logic wake_pin_enable,
	output logic wake_or_measure_select,
	output logic measure_run,
	output logic wake_pin_wake_active,
	output logic gpio_cfg_active,
	output pull_sel_s gpio_pull_select,
	output pull_sel_s wake_pin_pull_select,
	output logic wake_pin_level_flag,
	output logic gpio_level_flag,
	output logic irq_out_n
);
	logic [7:0] bus_q, bus_d;
	logic [7:0] iwk_q, iwk_d;
	logic [7:0] ewk_q, ewk_d;
	logic [7:0] pull_q, pull_d;
	logic [7:0] rdata_q, rdata_d;
	logic hit_q, hit_d;
	logic fail_q, fail_d;
	logic irq_n_q, irq_n_d;
	logic fo_s1_q, fo_s2_q;
	logic boot_q;
	logic [7:0] bus_rst;
	logic wr_bus, wr_iwk, wr_ewk, wr_pull;
	logic measure_refused;
	logic measuring;

	// fail output arrives from the pin driver domain; synchronise before use
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fo_s1_q <= 1'b0;
			fo_s2_q <= 1'b0;
		end else begin
			fo_s1_q <= fail_output;
			fo_s2_q <= fo_s1_q;
		end
	end

	// development strap is sampled just after reset release, never inside reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= 1'b0;
		end
	end

	assign bus_rst = dev_mode ? {6'b00_0000, MODE_NORMAL} : RST_BUS_MODE;

	// write decode
	assign wr_bus = req.wr && (req.addr == ADDR_BUS_MODE);
	assign wr_iwk = req.wr && (req.addr == ADDR_INT_WAKE);
	assign wr_ewk = req.wr && (req.addr == ADDR_EXT_WAKE);
	assign wr_pull = req.wr && (req.addr == ADDR_PULL_CFG);
	assign measure_refused = wr_ewk && req.wdata[BIT_MEASURE] && fo_s2_q && !ewk_q[BIT_MEASURE];
	assign measuring = ewk_q[BIT_MEASURE];

	// next values: fail-safe beats restart, restart beats a host write
	always_comb begin
		bus_d = bus_q;
		iwk_d = iwk_q;
		ewk_d = ewk_q;
		pull_d = pull_q;
		fail_d = measure_refused;
		if (boot_q) begin
			bus_d = bus_rst;
		end else if (failsafe_entry) begin
			bus_d = FS_BUS_MODE;
			if (!measuring) begin
				ewk_d = (ewk_q & FS_EXT_KEEP) | FS_EXT_SET;
			end
			// measuring: the wake pin is left as it is, not made a wake source
		end else if (restart_entry) begin
			bus_d = {6'b00_0000, restart_mode};
			iwk_d = iwk_q & KEEP_INT_WAKE;
			ewk_d = ewk_q & KEEP_EXT_WAKE;
			pull_d = pull_q & KEEP_PULL_CFG;
		end else begin
			if (wr_bus) begin
				bus_d = req.wdata & MASK_BUS_MODE;
			end
			if (wr_iwk) begin
				iwk_d = req.wdata & MASK_INT_WAKE;
			end
			if (wr_ewk) begin
				ewk_d = req.wdata & MASK_EXT_WAKE;
				if (measure_refused) begin
					ewk_d[BIT_MEASURE] = 1'b0;
				end
			end
			if (wr_pull) begin
				pull_d = req.wdata & MASK_PULL_CFG;
			end
		end
		// hardware clear on stop to normal wins over a host write in the same cycle
		if (stop_to_normal) begin
			iwk_d[BIT_DOG_STOP] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			bus_q <= RST_BUS_MODE;
			iwk_q <= RST_INT_WAKE;
			ewk_q <= RST_EXT_WAKE;
			pull_q <= RST_PULL_CFG;
			fail_q <= 1'b0;
		end else begin
			bus_q <= bus_d;
			iwk_q <= iwk_d;
			ewk_q <= ewk_d;
			pull_q <= pull_d;
			fail_q <= fail_d;
		end
	end

	// read path; registers only hold writable bits so reserved read zero
	always_comb begin
		rdata_d = 8'h00;
		hit_d = 1'b0;
		if (req.rd) begin
			hit_d = 1'b1;
			case (req.addr)
				ADDR_BUS_MODE: rdata_d = bus_q & MASK_BUS_MODE;
				ADDR_INT_WAKE: rdata_d = iwk_q & MASK_INT_WAKE;
				ADDR_EXT_WAKE: rdata_d = ewk_q & MASK_EXT_WAKE;
				ADDR_PULL_CFG: rdata_d = pull_q & MASK_PULL_CFG;
				default: hit_d = 1'b0;
			endcase
		end
	end

	// interrupt line: wakes always, other status only in global mode
	always_comb begin
		irq_n_d = !(wake_event || (ewk_q[BIT_GLOBAL_IRQ] && status_event));
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
			hit_q <= 1'b0;
			irq_n_q <= 1'b1;
		end else begin
			rdata_q <= rdata_d;
			hit_q <= hit_d;
			irq_n_q <= irq_n_d;
		end
	end

	// pin level flags freeze at reset value while measuring
	level_flag_hold u_wake_lvl (
		.clk(clk),
		.nrst(nrst),
		.pin(hv_wake_pin),
		.hold(measuring),
		.flag(wake_pin_level_flag)
	);

	level_flag_hold u_gpio_level_flag (
		.clk(clk),
		.nrst(nrst),
		.pin(gpio_pin),
		.hold(measuring),
		.flag(gpio_level_flag)
	);

	// decoded outputs straight from the stored fields
	always_comb begin
		xcvr_mode.off = (bus_q[1:0] == MODE_OFF);
		xcvr_mode.wake_only = (bus_q[1:0] == MODE_WAKE);
		xcvr_mode.rx_only = (bus_q[1:0] == MODE_RX_ONLY);
		xcvr_mode.normal = (bus_q[1:0] == MODE_NORMAL);
	end

	assign timer_wake_enable = iwk_q[BIT_TIMER_WAKE];
	assign dog_stop_disable_hi = iwk_q[BIT_DOG_STOP];
	assign wake_pin_enable = ewk_q[BIT_WAKE_EN];
	assign wake_or_measure_select = measuring;
	// measurement only runs in normal mode with the fail output idle
	assign measure_run = measuring && !fo_s2_q && in_normal;
	// a measuring pin never raises wake events and ignores its enable
	assign wake_pin_wake_active = ewk_q[BIT_WAKE_EN] && !measuring;
	assign gpio_cfg_active = !(measuring && !fo_s2_q);
	// gpio pull only applies while the gpio serves as a wake input
	assign gpio_pull_select = gpio_is_wake ? decode_pull(pull_q[PULL_GPIO_HI:PULL_GPIO_LO]) :
		decode_pull(PULL_NONE);
	assign wake_pin_pull_select = decode_pull(pull_q[PULL_WAKE_HI:PULL_WAKE_LO]);

	assign rdata = rdata_q;
	assign hit = hit_q;
	assign spi_fail_set = fail_q;
	assign irq_out_n = irq_n_q;
endmodule

// ### testbench/wake_cfg_properties.sv
// Purpose: temporal checks on the configuration bank ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the design top at the foot of this file
module wake_cfg_checker
	import wake_cfg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire reg_req_s req,
	input wire logic [7:0] rdata,
	input wire logic hit,
	input wire logic spi_fail_set,
	// mode events
	input wire logic failsafe_entry,
	input wire logic restart_entry,
	input wire logic stop_to_normal,
	input wire logic wake_event,
	// decoded outputs
	input wire xcvr_mode_s xcvr_mode,
	input wire logic timer_wake_enable,
	input wire logic dog_stop_disable_hi,
	input wire logic wake_pin_enable,
	input wire logic wake_or_measure_select,
	input wire logic wake_pin_level_flag,
	input wire logic irq_out_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// fail-safe entry while the wake pin is still a wake input
	sequence fs_plain;
		failsafe_entry && !wake_or_measure_select;
	endsequence
	a_mode_one_hot: assert property ($onehot(xcvr_mode))
		else $error("mode decode not one-hot");
	a_idle_zero: assert property (!$past(req.rd) |-> rdata == 8'h00 && !hit)
		else $error("read data outside a read");
	a_ext_reserved: assert property ($past(req.rd) && $past(req.addr) == ADDR_EXT_WAKE |-> (rdata & ~MASK_EXT_WAKE) == 8'h00)
		else $error("reserved bits read nonzero");
	a_fs_bus: assert property (failsafe_entry |=> xcvr_mode.wake_only)
		else $error("bus mode not forced wake capable");
	a_fs_wake: assert property (fs_plain |=> wake_pin_enable && !wake_or_measure_select)
		else $error("wake pin not forced on");
	a_fs_measure: assert property (failsafe_entry && wake_or_measure_select |=> wake_or_measure_select && $stable(wake_pin_enable))
		else $error("measure setup altered by fail-safe");
	a_dog_clear: assert property (stop_to_normal && !failsafe_entry |=> !dog_stop_disable_hi)
		else $error("stop disable survived normal entry");
	a_restart_keep: assert property (restart_entry && !failsafe_entry |=> !dog_stop_disable_hi && $stable(timer_wake_enable))
		else $error("restart internal wake value wrong");
	a_irq_wake: assert property (wake_event |=> !irq_out_n)
		else $error("wake did not pull interrupt low");
	a_level_hold: assert property (wake_or_measure_select && $past(wake_or_measure_select) |-> !wake_pin_level_flag)
		else $error("level flag moved while measuring");
	a_refuse_pulse: assert property (spi_fail_set |-> !wake_or_measure_select)
		else $error("measure select taken despite refusal");
endmodule

bind bus_and_wake_source_config wake_cfg_checker u_chk (.clk, .nrst, .req, .rdata, .hit, .spi_fail_set,
	.failsafe_entry, .restart_entry, .stop_to_normal, .wake_event, .xcvr_mode, .timer_wake_enable,
	.dog_stop_disable_hi, .wake_pin_enable, .wake_or_measure_select, .wake_pin_level_flag, .irq_out_n);

// ### testbench/host_model.sv
// Purpose: host side of the decoded register port
// Assumes: one request at a time, launched just after a rising edge
// Notes: a read samples its answer 1 ns after the edge that takes it
module host_model
	import wake_cfg_pkg::*;
(
	// clock
	input wire logic clk,
	// register port
	output reg_req_s req,
	input wire logic [7:0] rdata,
	input wire logic hit
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	// strobe stands for exactly the taking edge
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 req = '{1'b1, 1'b0, a, d};
		@(posedge clk);
		#1 req = '0;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic h);
		@(posedge clk);
		#1 req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		#1 req = '0;
		d = rdata;
		h = hit;
	endtask
endmodule

// ### testbench/test_bus_and_wake_source_config.sv
// Purpose: self-checking bench for the configuration bank
// Assumes: host model issues the register traffic
// Notes: pins are settled many edges before their flags are judged
module test_bus_and_wake_source_config import wake_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, dev_mode, failsafe_entry, restart_entry, stop_to_normal, in_normal, fail_output;
	logic hv_wake_pin, gpio_pin, gpio_is_wake, wake_event, status_event, hit, spi_fail_set;
	logic measure_run, wake_pin_wake_active, wake_pin_level_flag, irq_out_n, gpio_cfg_active, gpio_level_flag;
	logic [1:0] restart_mode;
	logic [7:0] rdata;
	reg_req_s req;
	xcvr_mode_s xcvr_mode;
	pull_sel_s gpio_pull_select, wake_pin_pull_select;
	int n_fail = 0, n_compared = 0, n_cyc = 0, n_sf = 0;

	bus_and_wake_source_config uut (.clk, .nrst, .req, .rdata, .hit, .spi_fail_set, .dev_mode, .failsafe_entry,
		.restart_entry, .restart_mode, .stop_to_normal, .in_normal, .fail_output, .hv_wake_pin, .gpio_pin,
		.gpio_is_wake, .wake_event, .status_event, .xcvr_mode, .timer_wake_enable(), .dog_stop_disable_hi(),
		.wake_pin_enable(), .wake_or_measure_select(), .measure_run, .wake_pin_wake_active, .gpio_cfg_active,
		.gpio_pull_select, .wake_pin_pull_select, .wake_pin_level_flag, .gpio_level_flag, .irq_out_n);
	host_model host (.clk, .req, .rdata, .hit);

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	// hang guard and refusal pulse counter
	always @(posedge clk) begin
		n_cyc++;
		if (spi_fail_set === 1'b1) n_sf++;
		if (n_cyc == 5000) begin
			n_fail++;
			wrap_up;
		end
	end
	task automatic wrap_up;
		if (n_fail == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic h;
		host.rd(a, d, h);
		chk(d, e);
		chk({7'h0, h}, 8'h01);
	endtask
	// one event pulse, interrupt level judged after it registers
	task automatic ev(input logic w, input logic s, input logic [7:0] e);
		wake_event = w;
		status_event = s;
		tick(1);
		chk({7'h0, irq_out_n}, e);
		wake_event = 0;
		status_event = 0;
	endtask
	task automatic t_reset_vals;
		logic [7:0] d;
		logic h;
		rc(ADDR_BUS_MODE, 8'h00);
		rc(ADDR_INT_WAKE, 8'h00);
		rc(ADDR_EXT_WAKE, 8'h01);
		rc(ADDR_PULL_CFG, 8'h00);
		host.rd(7'h05, d, h);
		chk(d | {7'h0, h}, 8'h00);
	endtask
	task automatic t_reserved;
		host.wr(ADDR_INT_WAKE, 8'hFF);
		host.wr(ADDR_PULL_CFG, 8'hFF);
		rc(ADDR_INT_WAKE, 8'h44);
		rc(ADDR_PULL_CFG, 8'hC3);
		chk({gpio_pull_select, wake_pin_pull_select}, 8'h11);
		for (int m = 0; m < 4; m++) begin
			host.wr(ADDR_BUS_MODE, 8'hFC | 8'(m));
			chk({4'h0, xcvr_mode}, 8'h08 >> m);
		end
	endtask
	task automatic t_failsafe;
		chk({5'h0, gpio_cfg_active, wake_pin_level_flag, gpio_level_flag}, 8'h07);
		host.wr(ADDR_EXT_WAKE, 8'h80);
		failsafe_entry = 1;
		tick(1);
		failsafe_entry = 0;
		rc(ADDR_BUS_MODE, 8'h01);
		rc(ADDR_EXT_WAKE, 8'h81);
		host.wr(ADDR_EXT_WAKE, 8'h20);
		tick(3);
		chk({5'h0, measure_run, wake_pin_wake_active, wake_pin_level_flag}, 8'h04);
		chk({6'h0, gpio_cfg_active, gpio_level_flag}, 8'h00);
		failsafe_entry = 1;
		tick(1);
		failsafe_entry = 0;
		rc(ADDR_EXT_WAKE, 8'h20);
		host.wr(ADDR_EXT_WAKE, 8'h01);
	endtask
	task automatic t_refuse;
		fail_output = 1;
		tick(3);
		host.wr(ADDR_EXT_WAKE, 8'hA1);
		tick(1);
		chk(8'(n_sf), 8'h01);
		rc(ADDR_EXT_WAKE, 8'h81);
		fail_output = 0;
	endtask
	task automatic t_restart;
		restart_mode = 2'h2;
		restart_entry = 1;
		tick(1);
		restart_entry = 0;
		rc(ADDR_BUS_MODE, 8'h02);
		rc(ADDR_INT_WAKE, 8'h40);
		rc(ADDR_EXT_WAKE, 8'h81);
		rc(ADDR_PULL_CFG, 8'hC3);
		host.wr(ADDR_INT_WAKE, 8'h44);
		stop_to_normal = 1;
		tick(1);
		stop_to_normal = 0;
		rc(ADDR_INT_WAKE, 8'h40);
	endtask
	task automatic t_irq;
		ev(0, 1, 8'h00);
		host.wr(ADDR_EXT_WAKE, 8'h01);
		tick(2);
		ev(0, 1, 8'h01);
		ev(1, 0, 8'h00);
	endtask
	task automatic t_dev;
		nrst = 0;
		dev_mode = 1;
		tick(8);
		nrst = 1;
		tick(1);
		rc(ADDR_BUS_MODE, 8'h03);
	endtask

	initial begin
		{nrst, dev_mode, failsafe_entry, restart_entry, stop_to_normal, fail_output} = '0;
		{wake_event, status_event, restart_mode} = '0;
		{in_normal, hv_wake_pin, gpio_pin, gpio_is_wake} = '1;
		tick(8);
		nrst = 1;
		tick(1);
		t_reset_vals;
		t_reserved;
		t_failsafe;
		t_refuse;
		t_restart;
		t_irq;
		t_dev;
		wrap_up;
	end
endmodule
